// ===== osc_trim_pkg.sv
// Constants, register map and helpers shared by the oscillator trim and
// supply monitor register bank.
// Assumes a single 40 MHz clock domain (mclk) for all users of the package.

package osc_trim_pkg;

  // ************************************************************
  // Widths
  // ************************************************************
  localparam int ADDR_W     = 7;
  localparam int DATA_W     = 8;
  localparam int CNT_W      = 16;
  localparam int TRIM_W     = 6;
  localparam int CTRL_W     = 4;
  localparam int MV_W       = 14;
  localparam int BITCNT_W   = 5;
  localparam int FRAME_BITS = 16;
  localparam int HDR_BITS   = 8;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [6:0] OFS_CONTROL     = 7'h00;
  localparam logic [6:0] OFS_GATE_SUPPLY = 7'h15;
  localparam logic [6:0] OFS_UV_THRESH   = 7'h1B;
  localparam logic [6:0] OFS_OSC_TRIM    = 7'h1C;
  localparam logic [6:0] OFS_COUNT_LO    = 7'h41;
  localparam logic [6:0] OFS_COUNT_HI    = 7'h42;
  localparam logic [6:0] OFS_BATTERY     = 7'h45;
  localparam logic [6:0] OFS_DIAG        = 7'h5F;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int BIT_CFG_DONE   = 0;
  localparam int BIT_OUT_ONE_EN = 1;
  localparam int BIT_OUT_TWO_EN = 2;
  localparam int BIT_COUNT_EN   = 3;
  localparam int DIAG_BIT_UV    = 3;
  localparam int DIAG_BIT_GOOD  = 5;
  localparam int FRAME_RW_BIT   = 8;

  // ************************************************************
  // Values after reset and fixed codes
  // ************************************************************
  localparam logic [3:0] RST_CONTROL     = 4'h0;
  localparam logic [7:0] RST_GATE_SUPPLY = 8'hA6;
  localparam logic [7:0] RST_UV_THRESH   = 8'h00;
  localparam logic [7:0] RST_BATTERY     = 8'h00;
  localparam logic [5:0] RST_OSC_TRIM    = 6'h09;
  localparam logic [7:0] GATE_CODE_FULL  = 8'hFF;
  localparam logic [13:0] GATE_STEP_MV   = 14'h003E;
  localparam logic [5:0] TRIM_HIGH_LO    = 6'h21;
  localparam logic [5:0] TRIM_HIGH_HI    = 6'h23;

  // Link frame phase
  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_FRAME = 2'b10} spi_state_t;

  // Odd codes only; of the 10xxxx group only two codes are usable
  function automatic logic trim_code_allowed(input logic [5:0] code);
    trim_code_allowed = code[0] &&
      ((code[5:4] != 2'b10) || (code == TRIM_HIGH_LO) || (code == TRIM_HIGH_HI));
  endfunction

  // Regulator target in millivolts from a gate supply code
  function automatic logic [13:0] gate_target_mv(input logic [7:0] code);
    gate_target_mv = 14'({6'h00, GATE_CODE_FULL - code} * GATE_STEP_MV);
  endfunction

endpackage

// ===== pin_sync.sv
// Two-stage synchroniser for pins that arrive from outside the mclk domain.
// Assumes the inputs are static or slow against mclk.
`timescale 1ns/1ps

module pin_sync #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             mclk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_one_reg;
  logic [WIDTH-1:0] stage_two_reg;

  // First stage feeds the second stage only
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stage_one_reg <= RESET_VAL;
      stage_two_reg <= RESET_VAL;
    end
    else
    begin
      stage_one_reg <= async_in;
      stage_two_reg <= stage_one_reg;
    end
  end

  assign sync_out = stage_two_reg;

endmodule // pin_sync

// ===== select_low_counter.sv
// Chip select low-time counter, counting in internal oscillator cycles.
// Assumes frame edge strobes and the low level come already synchronised.
`timescale 1ns/1ps

module select_low_counter #(
  parameter int CNT_WIDTH = osc_trim_pkg::CNT_W
) (
  input  wire logic                 mclk,
  input  wire logic                 rst_b,
  input  wire logic                 count_enable,
  input  wire logic                 cs_fall,
  input  wire logic                 cs_rise,
  input  wire logic                 cs_low,
  output logic      [CNT_WIDTH-1:0] select_low_count
);
  import osc_trim_pkg::*;

  logic [CNT_WIDTH-1:0] running_reg;
  logic [CNT_WIDTH-1:0] hold_reg;

  // One count per mclk period while low, restart and saturate
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      running_reg <= '0;
    else if (cs_fall && count_enable)
      running_reg <= '0;
    else if (cs_low && count_enable && !(&running_reg))
      running_reg <= running_reg + 1'b1;
  end

  // Latch at frame end using the enable as it stood during the frame
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      hold_reg <= '0;
    else if (cs_rise && count_enable)
      hold_reg <= running_reg;
  end

  assign select_low_count = hold_reg;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_count_freeze: assert property (!count_enable |=> $stable(hold_reg))
    else $error("count held value changed while disabled");
  a_count_restart: assert property (cs_fall && count_enable |=> running_reg == '0)
    else $error("count did not restart on select fall");
  a_count_saturate: assert property (&running_reg |=> &running_reg || $past(cs_fall))
    else $error("count wrapped past maximum");
  a_count_step: assert property (cs_low && count_enable && !cs_fall && !(&running_reg)
    |=> running_reg == $past(running_reg) + 1'b1)
    else $error("count did not advance one per cycle");
  c_count_latch: cover property (cs_rise && count_enable && running_reg != '0);

endmodule // select_low_counter

// ===== osc_trim_gate_supply_monitor.sv
// Register bank for oscillator trim, gate supply target and battery monitor,
// reached over the link pins (chip select, clock, data in, data out).
// Assumes the link is much slower than mclk and battery samples come on mclk.
`timescale 1ns/1ps

module osc_trim_gate_supply_monitor (
  input  wire logic                              mclk,
  input  wire logic                              rst_b,
  input  wire logic                              chip_select_pin_b,
  input  wire logic                              spi_clk_pin,
  input  wire logic                              spi_data_in_pin,
  output logic                                   spi_data_out,
  output logic                                   spi_data_out_en_b,
  input  wire logic                              gate_supply_good,
  input  wire logic                              battery_sample_valid,
  input  wire logic [osc_trim_pkg::DATA_W-1:0]   battery_sample_code,
  input  wire logic                              off_mode_entry,
  output logic      [osc_trim_pkg::TRIM_W-1:0]   osc_trim_code,
  output logic      [osc_trim_pkg::DATA_W-1:0]   gate_supply_code,
  output logic      [osc_trim_pkg::MV_W-1:0]     gate_supply_target_mv,
  output logic                                   regulator_enable,
  output logic                                   gate_run_one,
  output logic                                   gate_run_two,
  output logic                                   battery_monitor_active,
  output logic                                   supply_undervoltage_flag,
  output logic                                   fail_silent
);
  import osc_trim_pkg::*;

  // ************************************************************
  // Pin synchronisation and edge detection
  // ************************************************************
  logic [2:0]          pins_s;
  logic                cs_s;
  logic                sclk_s;
  logic                mosi_s;
  logic                good_s;
  logic                cs_prev_reg;
  logic                sclk_prev_reg;
  logic                cs_fall;
  logic                cs_rise;
  logic                sclk_rise;
  logic                sclk_fall;

  // Select idles high, clock and data idle low
  pin_sync #(.WIDTH(3), .RESET_VAL(3'h4)) u_link_sync (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .async_in ({chip_select_pin_b, spi_clk_pin, spi_data_in_pin}),
    .sync_out (pins_s)
  );

  // Gate supply good comes from the analog regulator
  pin_sync #(.WIDTH(1), .RESET_VAL(1'b0)) u_good_sync (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .async_in (gate_supply_good),
    .sync_out (good_s)
  );

  assign cs_s   = pins_s[2];
  assign sclk_s = pins_s[1];
  assign mosi_s = pins_s[0];

  // Previous levels for edge detection
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cs_prev_reg   <= 1'b1;
      sclk_prev_reg <= 1'b0;
    end
    else
    begin
      cs_prev_reg   <= cs_s;
      sclk_prev_reg <= sclk_s;
    end
  end

  assign cs_fall   = cs_prev_reg && !cs_s;
  assign cs_rise   = !cs_prev_reg && cs_s;
  assign sclk_rise = !sclk_prev_reg && sclk_s && !cs_s;
  assign sclk_fall = sclk_prev_reg && !sclk_s && !cs_s;

  // ************************************************************
  // Frame shifter
  // ************************************************************
  spi_state_t               state_reg;
  logic [FRAME_BITS-1:0]    shift_reg;
  logic [BITCNT_W-1:0]      bit_cnt_reg;
  logic                     hdr_done;
  logic [ADDR_W-1:0]        hdr_addr;
  logic                     wr_commit;
  logic [ADDR_W-1:0]        wr_addr;
  logic [DATA_W-1:0]        wr_data;

  // Frame phase follows chip select
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      state_reg <= ST_IDLE;
    else
    begin
      case (state_reg)
        ST_IDLE:  if (cs_fall) state_reg <= ST_FRAME;
        ST_FRAME: if (cs_rise) state_reg <= ST_IDLE;
        default:  state_reg <= ST_IDLE;
      endcase
    end
  end

  // Sample data on clock rise, count bits, stop counting past a full frame
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      shift_reg   <= '0;
      bit_cnt_reg <= '0;
    end
    else if (cs_fall)
      bit_cnt_reg <= '0;
    else if (sclk_rise && state_reg == ST_FRAME)
    begin
      shift_reg <= {shift_reg[FRAME_BITS-2:0], mosi_s};
      if (bit_cnt_reg != BITCNT_W'(FRAME_BITS + 1))
        bit_cnt_reg <= bit_cnt_reg + 1'b1;
    end
  end

  // Header: address then read flag; write commits on a clean 16-bit frame
  assign hdr_done  = sclk_rise && state_reg == ST_FRAME &&
                     bit_cnt_reg == BITCNT_W'(HDR_BITS - 1);
  assign hdr_addr  = shift_reg[ADDR_W-1:0];
  assign wr_addr   = shift_reg[FRAME_BITS-1:FRAME_RW_BIT+1];
  assign wr_data   = shift_reg[DATA_W-1:0];
  assign wr_commit = cs_rise && state_reg == ST_FRAME &&
                     bit_cnt_reg == BITCNT_W'(FRAME_BITS) && !shift_reg[FRAME_RW_BIT];

  // ************************************************************
  // Host-written configuration
  // ************************************************************
  logic [CTRL_W-1:0]  control_reg;
  logic [DATA_W-1:0]  gate_supply_reg;
  logic [DATA_W-1:0]  uv_thresh_reg;
  logic [TRIM_W-1:0]  trim_reg;
  logic               op_mode;
  logic               out_one_on;
  logic               out_two_on;

  // Reserved bits of control and trim are dropped on write
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      control_reg     <= RST_CONTROL;
      gate_supply_reg <= RST_GATE_SUPPLY;
      uv_thresh_reg   <= RST_UV_THRESH;
      trim_reg        <= RST_OSC_TRIM;
    end
    else if (wr_commit)
    begin
      case (wr_addr)
        OFS_CONTROL:     control_reg     <= wr_data[CTRL_W-1:0];
        OFS_GATE_SUPPLY: gate_supply_reg <= wr_data;
        OFS_UV_THRESH:   uv_thresh_reg   <= wr_data;
        OFS_OSC_TRIM:
          if (trim_code_allowed(wr_data[TRIM_W-1:0]))
            trim_reg <= wr_data[TRIM_W-1:0];
        default: ;
      endcase
    end
  end

  assign op_mode    = control_reg[BIT_CFG_DONE];
  assign out_one_on = op_mode && control_reg[BIT_OUT_ONE_EN];
  assign out_two_on = op_mode && control_reg[BIT_OUT_TWO_EN];

  // ************************************************************
  // Low-time counter
  // ************************************************************
  logic [CNT_W-1:0] select_low_count;

  select_low_counter #(.CNT_WIDTH(CNT_W)) u_counter (
    .mclk             (mclk),
    .rst_b            (rst_b),
    .count_enable     (control_reg[BIT_COUNT_EN]),
    .cs_fall          (cs_fall),
    .cs_rise          (cs_rise),
    .cs_low           (!cs_s),
    .select_low_count (select_low_count)
  );

  // ************************************************************
  // Battery monitor and undervoltage
  // ************************************************************
  logic               monitor_on;
  logic               uv_event;
  logic               uv_clear;
  logic [DATA_W-1:0]  battery_reg;
  logic               uv_flag_reg;
  logic               fail_silent_reg;

  assign monitor_on = (out_one_on || out_two_on) && good_s;
  assign uv_event   = battery_sample_valid && monitor_on &&
                      battery_sample_code < uv_thresh_reg;
  assign uv_clear   = (wr_commit && wr_addr == OFS_DIAG) || off_mode_entry;

  // Result only follows samples while monitoring
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      battery_reg <= RST_BATTERY;
    else if (battery_sample_valid && monitor_on)
      battery_reg <= battery_sample_code;
  end

  // Flag set wins over clear
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      uv_flag_reg <= 1'b0;
    else if (uv_event)
      uv_flag_reg <= 1'b1;
    else if (uv_clear)
      uv_flag_reg <= 1'b0;
  end

  // Fail silent holds until reset
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      fail_silent_reg <= 1'b0;
    else if (uv_event)
      fail_silent_reg <= 1'b1;
  end

  // ************************************************************
  // Registered outputs to the power stage
  // ************************************************************
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      regulator_enable       <= 1'b0;
      gate_run_one           <= 1'b0;
      gate_run_two           <= 1'b0;
      battery_monitor_active <= 1'b0;
      gate_supply_target_mv  <= gate_target_mv(RST_GATE_SUPPLY);
    end
    else
    begin
      regulator_enable       <= out_one_on || out_two_on;
      gate_run_one           <= out_one_on && good_s && !fail_silent_reg;
      gate_run_two           <= out_two_on && good_s && !fail_silent_reg;
      battery_monitor_active <= monitor_on;
      gate_supply_target_mv  <= gate_target_mv(gate_supply_reg);
    end
  end

  assign osc_trim_code            = trim_reg;
  assign gate_supply_code         = gate_supply_reg;
  assign supply_undervoltage_flag = uv_flag_reg;
  assign fail_silent              = fail_silent_reg;

  // ************************************************************
  // Read path
  // ************************************************************
  logic [DATA_W-1:0] read_data;
  logic [DATA_W-1:0] miso_reg;

  // Register map seen by the host
  always_comb
  begin
    case (hdr_addr)
      OFS_CONTROL:     read_data = {4'h0, control_reg};
      OFS_GATE_SUPPLY: read_data = gate_supply_reg;
      OFS_UV_THRESH:   read_data = uv_thresh_reg;
      OFS_OSC_TRIM:    read_data = {2'b00, trim_reg};
      OFS_COUNT_LO:    read_data = select_low_count[7:0];
      OFS_COUNT_HI:    read_data = select_low_count[15:8];
      OFS_BATTERY:     read_data = battery_reg;
      OFS_DIAG:        read_data = (8'(good_s) << DIAG_BIT_GOOD) |
                                   (8'(uv_flag_reg) << DIAG_BIT_UV);
      default:         read_data = 8'h00;
    endcase
  end

  // Load after the header, shift on each clock fall in the data phase
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      miso_reg <= '0;
    else if (cs_fall)
      miso_reg <= '0;
    else if (hdr_done)
      miso_reg <= mosi_s ? read_data : 8'h00;
    else if (sclk_fall && bit_cnt_reg > BITCNT_W'(HDR_BITS))
      miso_reg <= {miso_reg[DATA_W-2:0], 1'b0};
  end

  assign spi_data_out      = miso_reg[DATA_W-1];
  assign spi_data_out_en_b = cs_s;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_count_en_write: assert property (wr_commit && wr_addr == OFS_CONTROL
    |=> control_reg[BIT_COUNT_EN] == $past(wr_data[BIT_COUNT_EN]))
    else $error("count enable not taken from bit 3");
  a_trim_filter: assert property (wr_commit && wr_addr == OFS_OSC_TRIM
    |=> trim_reg == ($past(trim_code_allowed(wr_data[5:0])) ? $past(wr_data[5:0])
                                                             : $past(trim_reg)))
    else $error("trim write filtering wrong");
  a_gate_readback: assert property (wr_commit && wr_addr == OFS_GATE_SUPPLY
    |=> gate_supply_code == $past(wr_data))
    else $error("gate supply code not stored");
  a_gate_target: assert property (##1 gate_supply_target_mv ==
    gate_target_mv($past(gate_supply_reg)))
    else $error("gate supply millivolts wrong");
  a_battery_gate: assert property (!monitor_on |=> $stable(battery_reg))
    else $error("battery result moved while monitor off");
  a_battery_take: assert property (battery_sample_valid && monitor_on
    |=> battery_reg == $past(battery_sample_code))
    else $error("battery sample not captured");
  a_uv_trip: assert property (uv_event |=> uv_flag_reg && fail_silent_reg)
    else $error("undervoltage did not trip");
  a_uv_clear: assert property (uv_clear && !uv_event |=> !uv_flag_reg)
    else $error("undervoltage flag not cleared");
  a_fail_hold: assert property (fail_silent_reg |=> fail_silent_reg ##1 !gate_run_one
    && !gate_run_two)
    else $error("fail silent released or gates running");
  a_count_read: assert property (hdr_done && mosi_s && hdr_addr == OFS_COUNT_HI
    |=> miso_reg == $past(select_low_count[15:8]))
    else $error("count high byte not returned");

  c_uv_trip:    cover property (uv_event);
  c_trim_write: cover property (wr_commit && wr_addr == OFS_OSC_TRIM);
  c_read_frame: cover property (hdr_done && mosi_s && hdr_addr == OFS_COUNT_LO);

endmodule // osc_trim_gate_supply_monitor

// ===== spi_host_model.sv
// Link host model: frames of 16 bits, address, read flag, data, MSB first.
// Assumes mclk at 40 MHz; link clock period is 8 mclk (200 ns), idle low.
`timescale 1ns/1ps

module spi_host_model (
  input  wire logic mclk,
  output logic      chip_select_pin_b,
  output logic      spi_clk_pin,
  output logic      spi_data_in_pin,
  input  wire logic spi_data_out,
  input  wire logic spi_data_out_en_b
);
  // Idle link at time zero
  initial
  begin
    chip_select_pin_b = 1'b1;
    spi_clk_pin = 1'b0;
    spi_data_in_pin = 1'b0;
  end

  // One frame; tail stretches the select low time after the last bit
  task automatic xfer(input logic [6:0] a, input logic rw, input logic [7:0] d,
                      input int tail, output logic [7:0] q);
    logic [15:0] f;
    f = {a, rw, d};
    q = 8'h00;
    @(posedge mclk);
    chip_select_pin_b <= 1'b0;
    spi_data_in_pin <= f[15];
    for (int i = 15; i >= 0; i--)
    begin
      repeat (4) @(posedge mclk);
      spi_clk_pin <= 1'b1;
      if (i < 8)
        q[i] = spi_data_out; // Sampled on the rising link edge
      repeat (4) @(posedge mclk);
      spi_clk_pin <= 1'b0;
      if (i > 0)
        spi_data_in_pin <= f[i-1];
    end
    repeat (4 + tail) @(posedge mclk);
    chip_select_pin_b <= 1'b1;
    spi_data_in_pin <= ~spi_data_in_pin; // Released line shows no stale bit
    repeat (8) @(posedge mclk);
  endtask
endmodule // spi_host_model

// ===== test_osc_trim_gate_supply_monitor.sv
// Self-checking bench for the trim, gate supply and battery register bank.
// Assumes the package, the design files and spi_host_model are compiled first.
`timescale 1ns/1ps

module test_osc_trim_gate_supply_monitor;
  import osc_trim_pkg::*;
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic        cs_b, sclk, mosi, miso, miso_en_b, reg_en, run1, run2, mon, uv, fs;
  logic        good = 1'b0;
  logic        bval = 1'b0;
  logic        off = 1'b0;
  logic [7:0]  bcode = 8'h00;
  logic [5:0]  trim;
  logic [7:0]  gcode;
  logic [13:0] gmv;
  int          n_errors = 0;
  int          checks_done = 0;
  logic [7:0]  tw [4] = '{8'h11, 8'h10, 8'h25, 8'h23};
  logic [7:0]  te [4] = '{8'h11, 8'h11, 8'h11, 8'h23};

  // Clock at 40 MHz
  always #12.5 mclk = ~mclk;

  spi_host_model host (.mclk(mclk), .chip_select_pin_b(cs_b), .spi_clk_pin(sclk),
    .spi_data_in_pin(mosi), .spi_data_out(miso), .spi_data_out_en_b(miso_en_b));

  osc_trim_gate_supply_monitor dut (.mclk(mclk), .rst_b(rst_b), .chip_select_pin_b(cs_b),
    .spi_clk_pin(sclk), .spi_data_in_pin(mosi), .spi_data_out(miso),
    .spi_data_out_en_b(miso_en_b), .gate_supply_good(good), .battery_sample_valid(bval),
    .battery_sample_code(bcode), .off_mode_entry(off), .osc_trim_code(trim),
    .gate_supply_code(gcode), .gate_supply_target_mv(gmv), .regulator_enable(reg_en),
    .gate_run_one(run1), .gate_run_two(run2), .battery_monitor_active(mon),
    .supply_undervoltage_flag(uv), .fail_silent(fs));

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic print_verdict;
    $display("Checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d, input int tail = 0);
    logic [7:0] q;
    host.xfer(a, 1'b0, d, tail, q);
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] e, input string n);
    logic [7:0] q;
    host.xfer(a, 1'b1, 8'h00, 0, q);
    check(n, {8'h00, q}, {8'h00, e});
  endtask

  task automatic sample(input logic [7:0] c);
    @(posedge mclk);
    bval <= 1'b1;
    bcode <= c;
    @(posedge mclk);
    bval <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask

  // ************************************************************
  // Test sequence
  // ************************************************************
  initial
  begin
    logic [7:0] q;
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    check("trim rst", {10'h000, trim}, 16'h0009);
    check("mv rst", {2'b00, gmv}, 16'h158E);
    repeat (2) @(posedge mclk);
    rd(OFS_GATE_SUPPLY, 8'hA6, "gate rst");
    wr(OFS_GATE_SUPPLY, 8'hB6);
    rd(OFS_GATE_SUPPLY, 8'hB6, "gate min");
    check("mv min", {2'b00, gmv}, 16'h11AE);
    wr(OFS_GATE_SUPPLY, 8'hA7);
    rd(OFS_GATE_SUPPLY, 8'hA7, "gate max");
    check("mv max", {2'b00, gmv}, 16'h1550);
    // Allowed, even and unlisted trim codes, trimmed before any use
    for (int i = 0; i < 4; i++)
    begin
      wr(OFS_OSC_TRIM, tw[i]);
      rd(OFS_OSC_TRIM, te[i], "trim");
    end
    check("trim pin", {10'h000, trim}, 16'h0023);
    // Measure after the trim: enable, then clear with a frame low 172 cycles
    wr(OFS_CONTROL, 8'h08);
    wr(OFS_CONTROL, 8'h00, 40);
    rd(OFS_COUNT_HI, 8'h00, "cnt hi");
    host.xfer(OFS_COUNT_LO, 1'b1, 8'h00, 0, q);
    check("cnt lo", {15'h0000, (q inside {[8'hAB:8'hAD]})}, 16'h0001);
    rd(OFS_COUNT_LO, q, "cnt frozen");
    rd(7'h30, 8'h00, "unmapped");
    // Battery monitor off, then on with output one
    good <= 1'b1;
    sample(8'h33);
    rd(OFS_BATTERY, 8'h00, "bat off");
    wr(OFS_UV_THRESH, 8'h50);
    wr(OFS_CONTROL, 8'h03);
    repeat (6) @(posedge mclk);
    check("mon run", {12'h000, mon, reg_en, run1, run2}, 16'h000E);
    sample(8'h50);
    rd(OFS_BATTERY, 8'h50, "bat");
    check("uv equal", {14'h0000, uv, fs}, 16'h0000);
    sample(8'h4F);
    check("uv below", {13'h0000, uv, fs, run1}, 16'h0006);
    wr(OFS_DIAG, 8'h00);
    check("uv clear", {14'h0000, uv, fs}, 16'h0001);
    // Trip again, then clear through off mode entry
    sample(8'h4E);
    check("uv again", {14'h0000, uv, fs}, 16'h0003);
    @(posedge mclk);
    off <= 1'b1;
    @(posedge mclk);
    off <= 1'b0;
    repeat (2) @(posedge mclk);
    check("uv off mode", {14'h0000, uv, fs}, 16'h0001);
    print_verdict;
  end

  // Watchdog well beyond the expected 3500 cycles
  initial
  begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    print_verdict;
  end
endmodule // test_osc_trim_gate_supply_monitor
